// file: rtl/sbpa_regs.svh
// Purpose: Timing counts, pin indices and reset levels of the system bus priority arbiter.
// Assumes: 50 MHz core clock; bus pins are active low.
// Notes: Definitions only.
// What this block does
// - Acquire the shared bus when a transfer is needed, release it afterwards.
// - Only one master drives the bus clocks; each can disable driving them.
// - Serial mode: a requesting master drives priority-out high, blocking lower masters.
// - Serial mode: when finished with the bus, priority-out returns low if priority-in is asserted.
// - Serial mode: priority held but bus unneeded, priority-out is driven low.
// - Parallel mode: priority-out is disabled on every master.
// - Asserted priority-in, sampled on bus clock, means no higher master requests.
// - Parallel mode: bus request asserted on bus clock while bus is needed.
// - Holder asserts busy on bus clock; nobody else takes the bus meanwhile.
// - Common request asserted while waiting, released once control is obtained.
`ifndef SBPA_REGS_SVH
`define SBPA_REGS_SVH
`define SBPA_CLK_PERIOD_PS 20000
`define SBPA_BCLK_PERIOD_PS 102500
`define SBPA_BCLK_HALF_CYC ((`SBPA_BCLK_PERIOD_PS / 2) / `SBPA_CLK_PERIOD_PS)
`define SBPA_PIN_IDLE 1'b1
`define SBPA_NUM_PINS 4
`define SBPA_IDX_BCLK 0
`define SBPA_IDX_BPRN 1
`define SBPA_IDX_BUSY 2
`define SBPA_IDX_CBRQ 3
`endif

// file: rtl/sbpa_pkg.sv
// Purpose: Types shared by the arbiter files.
// Assumes: Nothing beyond the header.
// Notes: Constants live in sbpa_regs.svh.
package sbpa_pkg;
  typedef enum logic [1:0] {
    SBPA_IDLE,
    SBPA_WAIT,
    SBPA_OWN
  } sbpa_state_t;
endpackage : sbpa_pkg

// file: rtl/sbpa_sync_if.sv
// Purpose: Carries raw bus pins into the synchroniser and clean levels back.
// Assumes: One clock domain on the consumer side.
// Notes: Width set by the instantiating module.
`timescale 1ns/100ps
interface sbpa_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  modport sync (input raw, output lvl);
  modport user (output raw, input lvl);
endinterface : sbpa_sync_if

// file: rtl/sbpa_pin_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for asynchronous bus pins.
// Assumes: Inputs are idle high after reset.
// Notes: A change counts only once stages two and three agree.
`timescale 1ns/100ps
`include "sbpa_regs.svh"
module sbpa_pin_sync #(
  parameter int W = `SBPA_NUM_PINS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Pins in, levels out
  sbpa_sync_if.sync port
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= {W{`SBPA_PIN_IDLE}};
      s2_r <= {W{`SBPA_PIN_IDLE}};
      s3_r <= {W{`SBPA_PIN_IDLE}};
    end else if (i_clk_en) begin
      s1_r <= port.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit only where the last two stages agree, filtering one-sample glitches
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lvl_r <= {W{`SBPA_PIN_IDLE}};
    end else if (i_clk_en) begin
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
    end
  end

  assign port.lvl = lvl_r;
endmodule : sbpa_pin_sync

// file: rtl/sbpa_arbiter.sv
// Purpose: Bus arbitration for a full master on a shared system bus, serial or parallel priority.
// Assumes: Bus clock pin sampled by i_clock; open-collector pins resolved outside.
// Notes: Decisions are taken on the falling edge of the bus clock pin as seen after sync.
`timescale 1ns/100ps
`include "sbpa_regs.svh"
module sbpa_arbiter #(
  parameter int unsigned HALF_CYC = `SBPA_BCLK_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Configuration
  input wire logic i_parallel_mode,
  input wire logic i_clk_drive_en,
  // User side
  input wire logic i_bus_req,
  output logic o_bus_grant,
  output sbpa_pkg::sbpa_state_t o_arb_state,
  // Bus pins in
  input wire logic i_bclk_n,
  input wire logic i_bprn_n,
  input wire logic i_busy_n,
  input wire logic i_cbrq_n,
  // Bus pins out
  output logic o_bpro_n,
  output logic o_bpro_oe,
  output logic o_breq_n,
  output logic o_busy_n,
  output logic o_busy_oe,
  output logic o_cbrq_n,
  output logic o_cbrq_oe,
  output logic o_bclk_n,
  output logic o_bclk_oe,
  output logic o_cclk_n,
  output logic o_cclk_oe
);
  import sbpa_pkg::*;

  sbpa_sync_if #(.W(`SBPA_NUM_PINS)) pins ();
  sbpa_state_t state_r;
  sbpa_state_t state_nxt;
  logic bclk_d_r;
  logic bclk_fall;
  logic bprn_ok;
  logic bus_free;
  logic take_ok;
  logic mode_r;
  logic drive_r;
  logic bpro_n_r;
  logic breq_n_r;
  logic busy_oe_r;
  logic cbrq_oe_r;
  logic grant_r;
  logic [7:0] div_cnt_r;
  logic bclk_gen_r;

  // All bus inputs come from outside this clock domain
  assign pins.raw = {i_cbrq_n, i_busy_n, i_bprn_n, i_bclk_n};

  sbpa_pin_sync #(.W(`SBPA_NUM_PINS)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .port(pins.sync)
  );

  // Bus clock edge detection on the filtered level
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bclk_d_r <= `SBPA_PIN_IDLE;
    end else if (i_clk_en) begin
      bclk_d_r <= pins.lvl[`SBPA_IDX_BCLK];
    end
  end

  assign bclk_fall = bclk_d_r & ~pins.lvl[`SBPA_IDX_BCLK];
  assign bprn_ok = ~pins.lvl[`SBPA_IDX_BPRN];
  assign bus_free = pins.lvl[`SBPA_IDX_BUSY];
  // Conditions for taking the bus, kept apart so the grant check does not reuse the state decode
  assign take_ok = bclk_fall & bprn_ok & bus_free;

  // Configuration captured so mode changes land cleanly
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (i_clk_en) begin
      mode_r <= i_parallel_mode;
      drive_r <= i_clk_drive_en;
    end
  end

  // Arbitration state machine, advanced only on bus clock edges
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SBPA_IDLE: begin
        if (bclk_fall && i_bus_req) begin
          state_nxt = SBPA_WAIT;
        end
      end
      SBPA_WAIT: begin
        if (bclk_fall && !i_bus_req) begin
          state_nxt = SBPA_IDLE;
        end else if (bclk_fall && bprn_ok && bus_free) begin
          state_nxt = SBPA_OWN;
        end
      end
      SBPA_OWN: begin
        if (bclk_fall && !i_bus_req) begin
          state_nxt = SBPA_IDLE;
        end
      end
      default: begin
        state_nxt = SBPA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= SBPA_IDLE;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Arbitration pins registered from the next state so they move with it
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bpro_n_r <= 1'b0;
      breq_n_r <= 1'b1;
      busy_oe_r <= 1'b0;
      cbrq_oe_r <= 1'b0;
      grant_r <= 1'b0;
    end else if (i_clk_en) begin
      // block lower masters; pass priority down when idle
      bpro_n_r <= pins.lvl[`SBPA_IDX_BPRN] | (state_nxt != SBPA_IDLE);
      breq_n_r <= ~(i_parallel_mode && (state_nxt != SBPA_IDLE));
      busy_oe_r <= (state_nxt == SBPA_OWN);
      cbrq_oe_r <= (state_nxt == SBPA_WAIT);
      grant_r <= (state_nxt == SBPA_OWN);
    end
  end

  // Bus clock generator; the ratio cannot hit the nominal period exactly, so it rounds faster
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 8'h00;
      bclk_gen_r <= 1'b1;
    end else if (i_clk_en) begin
      if (div_cnt_r >= 8'(HALF_CYC - 1)) begin
        div_cnt_r <= 8'h00;
        bclk_gen_r <= ~bclk_gen_r;
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  assign o_bpro_oe = ~mode_r;
  assign o_bpro_n = bpro_n_r;
  assign o_breq_n = breq_n_r;
  // Open-collector pins only ever pull low
  assign o_busy_n = 1'b0;
  assign o_busy_oe = busy_oe_r;
  assign o_cbrq_n = 1'b0;
  assign o_cbrq_oe = cbrq_oe_r;
  assign o_bclk_n = bclk_gen_r;
  assign o_bclk_oe = drive_r;
  assign o_cclk_n = bclk_gen_r;
  assign o_cclk_oe = drive_r;
  assign o_bus_grant = grant_r;
  assign o_arb_state = state_r;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_clk_en);

  chk_take_when_free: assert property (
    $rose(o_bus_grant) |-> $past(take_ok)
  ) else $error("bus taken without priority or while busy");

  chk_prio_gate: assert property (
    (state_r == SBPA_WAIT && !bprn_ok) |=> state_r != SBPA_OWN
  ) else $error("bus taken with priority-in deasserted");

  chk_busy_held: assert property (
    (state_r == SBPA_OWN) |-> (o_busy_oe && !o_busy_n && o_bus_grant)
  ) else $error("busy not driven while owning bus");

  chk_cbrq_drop: assert property (
    $rose(state_r == SBPA_OWN) |-> !o_cbrq_oe ##1 !o_cbrq_oe
  ) else $error("common request still driven after grant");

  chk_bpro_block: assert property (
    (!mode_r && state_r != SBPA_IDLE) |-> (o_bpro_n && o_bpro_oe)
  ) else $error("priority-out not blocking while requesting");

  chk_bpro_release: assert property (
    (state_r == SBPA_OWN && state_nxt == SBPA_IDLE && !pins.lvl[`SBPA_IDX_BPRN] && !mode_r)
      |=> !o_bpro_n
  ) else $error("priority-out not released after bus use");

  chk_bpro_pass: assert property (
    (state_r == SBPA_IDLE && state_nxt == SBPA_IDLE && !pins.lvl[`SBPA_IDX_BPRN]) |=> !o_bpro_n
  ) else $error("idle holder of priority does not pass it on");

  chk_parallel_req: assert property (
    (mode_r && $past(i_parallel_mode) && state_r != SBPA_IDLE) |-> (!o_breq_n && !o_bpro_oe)
  ) else $error("parallel request missing or priority-out enabled");

  chk_clk_disable: assert property (
    !$past(i_clk_drive_en) |-> (!o_bclk_oe && !o_cclk_oe)
  ) else $error("bus clocks driven while disabled");

  chk_release_done: assert property (
    (state_r == SBPA_OWN && bclk_fall && !i_bus_req) |=> (state_r == SBPA_IDLE && !o_busy_oe)
  ) else $error("bus not released after need ended");

  cov_serial_grant: cover property (!mode_r && $rose(state_r == SBPA_OWN));
  cov_parallel_grant: cover property (mode_r && $rose(state_r == SBPA_OWN));
  cov_wait_blocked: cover property (state_r == SBPA_WAIT && bclk_fall && !bus_free);
  cov_release: cover property (state_r == SBPA_OWN ##1 state_r == SBPA_IDLE);
endmodule : sbpa_arbiter

// file: testbench/sbpa_bus_model.sv
// Purpose: Backplane partner: bus clock source, priority-in, open-collector wires.
// Assumes: Bench sets the other masters' demands on its clock.
// Notes: Wired-OR lines go low when any party enables its driver.
`timescale 1ns/100ps
module sbpa_bus_model #(
  // Encoder input the device is wired to; any value 0..6 leaves a higher input free
  parameter int DEV_RANK = 3
) (
  // Demands of other masters
  input logic i_block,
  input logic i_other_busy,
  input logic i_other_cbrq,
  input logic [7:0] i_other_req,
  // Scheme selection
  input logic i_parallel,
  // Device drivers
  input logic i_busy_oe,
  input logic i_cbrq_oe,
  input logic i_bclk_n,
  input logic i_bclk_oe,
  input logic i_breq_n,
  input logic i_bpro_n,
  input logic i_bpro_oe,
  // Resolved wires
  output logic o_bclk_n,
  output logic o_bprn_n,
  output logic o_busy_n,
  output logic o_cbrq_n,
  output logic o_low_bprn_n
);
  logic own_bclk_n = 1'b1;
  logic dev_wins;
  // one clock source
  // Free-running 160 ns clock, odd phase to the core clock; yields to the device driver
  initial begin
    #37;
    forever #80 own_bclk_n = ~own_bclk_n;
  end
  assign o_bclk_n = i_bclk_oe ? i_bclk_n : own_bclk_n;
  // external encoder: input 7 wins, input 0 lowest; a second one would extend it to sixteen
  assign dev_wins = ~i_breq_n & ~|(i_other_req >> (DEV_RANK + 1));
  // upper master's priority-out (i_block) in serial mode; decoder grant in parallel mode
  assign o_bprn_n = i_parallel ? ~dev_wins : i_block;
  // three-slot chain: upper master, device, lower master; a disabled output floats high
  assign o_low_bprn_n = i_bpro_oe ? i_bpro_n : 1'b1;
  assign o_busy_n = ~(i_busy_oe | i_other_busy);
  assign o_cbrq_n = ~(i_cbrq_oe | i_other_cbrq);
endmodule : sbpa_bus_model

// file: testbench/system_bus_priority_arbiter_test.sv
// Purpose: Self-checking bench for the bus arbiter, serial and parallel priority.
// Assumes: Bus clock period 160 ns from the model unless the device drives it.
// Notes: Inputs change 1 ns after the rising edge; waits are bounded.
`timescale 1ns/100ps
module system_bus_priority_arbiter_test;
  import sbpa_pkg::*;
  logic clock = 1'b0;
  logic rst, par_mode, drive_en, bus_req, block, other_busy;
  logic grant, bpro_n, bpro_oe, breq_n, busy_n, busy_oe, cbrq_n, cbrq_oe;
  logic bclk_n, bclk_oe, cclk_n, cclk_oe, bclk_w, bprn_w, busy_w, cbrq_w, v;
  logic clk_en, low_bprn_w;
  logic [7:0] other_req;
  sbpa_state_t arb_state;
  int fails = 0;
  int total_checks = 0;
  // 50 MHz core clock
  initial begin
    forever #10 clock = ~clock;
  end
  sbpa_arbiter #(.HALF_CYC(2)) i_dut (.i_clock(clock), .i_rst(rst), .i_clk_en(clk_en),
    .i_parallel_mode(par_mode), .i_clk_drive_en(drive_en), .i_bus_req(bus_req),
    .o_bus_grant(grant), .o_arb_state(arb_state), .i_bclk_n(bclk_w), .i_bprn_n(bprn_w),
    .i_busy_n(busy_w), .i_cbrq_n(cbrq_w), .o_bpro_n(bpro_n), .o_bpro_oe(bpro_oe),
    .o_breq_n(breq_n), .o_busy_n(busy_n), .o_busy_oe(busy_oe), .o_cbrq_n(cbrq_n),
    .o_cbrq_oe(cbrq_oe), .o_bclk_n(bclk_n), .o_bclk_oe(bclk_oe), .o_cclk_n(cclk_n),
    .o_cclk_oe(cclk_oe));
  sbpa_bus_model #(.DEV_RANK(3)) i_bus (.i_block(block), .i_other_busy(other_busy), .i_other_cbrq(1'b0),
    .i_other_req(other_req), .i_parallel(par_mode), .i_busy_oe(busy_oe), .i_cbrq_oe(cbrq_oe),
    .i_bclk_n(bclk_n), .i_bclk_oe(bclk_oe), .i_breq_n(breq_n), .i_bpro_n(bpro_n), .i_bpro_oe(bpro_oe),
    .o_bclk_n(bclk_w), .o_bprn_n(bprn_w), .o_busy_n(busy_w), .o_cbrq_n(cbrq_w), .o_low_bprn_n(low_bprn_w));
  task automatic check(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles
  // Bounded wait; a stuck arbiter ends the run
  task automatic wait_state(input sbpa_state_t s);
    int n;
    n = 0;
    while (arb_state !== s && n < 200) begin
      cycles(1);
      n++;
    end
    if (arb_state !== s) begin
      fails++;
      $display("Error at %0t: state wait timed out", $time);
      test_done();
    end
  endtask : wait_state
  task automatic test_serial;
    check(bpro_n, 1'b0, "idle priority not passed on");
    bus_req = 1'b1;
    wait_state(SBPA_WAIT);
    check(bpro_n, 1'b1, "priority-out low while requesting");
    check(cbrq_oe, 1'b1, "no common request while waiting");
    check(breq_n, 1'b1, "bus request in serial mode");
    check(cbrq_w, 1'b0, "common request wire not pulled low");
    check(low_bprn_w, 1'b1, "lower slot not blocked");
    wait_state(SBPA_OWN);
    check(grant, 1'b1, "no grant on owning");
    check(cbrq_oe, 1'b0, "common request kept after grant");
    check(cbrq_w, 1'b1, "common request wire held after grant");
    cycles(48);
    check(busy_w, 1'b0, "busy dropped while owning");
    check(grant, 1'b1, "grant lost while requested");
    bus_req = 1'b0;
    wait_state(SBPA_IDLE);
    check(busy_oe, 1'b0, "busy kept after release");
    check(bpro_n, 1'b0, "priority-out not returned low");
    check(low_bprn_w, 1'b0, "priority not offered to lower slot");
    $display("Test serial done");
  endtask : test_serial
  task automatic test_refused;
    block = 1'b1;
    bus_req = 1'b1;
    wait_state(SBPA_WAIT);
    cycles(48);
    check(arb_state === SBPA_WAIT, 1'b1, "took bus without priority");
    check(bpro_n, 1'b1, "blocked chain not passed high");
    block = 1'b0;
    other_busy = 1'b1;
    cycles(48);
    check(grant, 1'b0, "took bus while busy");
    check(cbrq_oe, 1'b1, "common request lost while waiting");
    other_busy = 1'b0;
    wait_state(SBPA_OWN);
    clk_en = 1'b0;
    bus_req = 1'b0;
    cycles(48);
    check(grant, 1'b1, "state moved while clock disabled");
    check(busy_w, 1'b0, "busy dropped while clock disabled");
    clk_en = 1'b1;
    wait_state(SBPA_IDLE);
    $display("Test refused done");
  endtask : test_refused
  task automatic test_parallel;
    par_mode = 1'b1;
    cycles(2);
    check(bpro_oe, 1'b0, "priority-out enabled in parallel");
    check(low_bprn_w, 1'b1, "disabled priority-out not floating high");
    other_req = 8'h80;
    bus_req = 1'b1;
    wait_state(SBPA_WAIT);
    check(breq_n, 1'b0, "no bus request while waiting");
    cycles(48);
    check(grant, 1'b0, "took bus from a higher rank");
    other_req = 8'h01;
    wait_state(SBPA_OWN);
    check(breq_n, 1'b0, "bus request dropped while owning");
    bus_req = 1'b0;
    wait_state(SBPA_IDLE);
    check(breq_n, 1'b1, "bus request kept after release");
    other_req = 8'h00;
    par_mode = 1'b0;
    cycles(2);
    check(bpro_oe, 1'b1, "priority-out off in serial");
    $display("Test parallel done");
  endtask : test_parallel
  task automatic test_clocks;
    drive_en = 1'b1;
    cycles(2);
    check(bclk_oe & cclk_oe, 1'b1, "bus clocks not driven");
    v = bclk_w;
    cycles(2);
    check(bclk_w, ~v, "bus clock not toggling");
    check(cclk_n, ~v, "constant clock not toggling");
    test_serial();
    drive_en = 1'b0;
    cycles(2);
    check(bclk_oe | cclk_oe, 1'b0, "bus clocks not released");
    $display("Test clocks done");
  endtask : test_clocks
  // Main sequence
  initial begin
    rst = 1'b1;
    par_mode = 1'b0;
    drive_en = 1'b0;
    bus_req = 1'b0;
    block = 1'b0;
    other_busy = 1'b0;
    clk_en = 1'b1;
    other_req = 8'h00;
    cycles(2);
    rst = 1'b0;
    cycles(8);
    check(grant | busy_oe | cbrq_oe, 1'b0, "reset outputs");
    test_serial();
    test_refused();
    test_parallel();
    test_clocks();
    test_done();
  end
endmodule : system_bus_priority_arbiter_test
